// file: src/dcswc_channel.sv
// Notes on behaviour
// - A clear event loads zero-scale when the clear-level bit is 0 and mid-scale when it is 1.
// - With update-sync clear, a written code becomes the output target right after the write completes.
// - With update-sync set, a written code waits for a load pin falling edge or a written load bit.
// - Broadcast writes are taken only while the broadcast-accept bit is 1 and ignored otherwise.
// - Phase select 00, 01, 10, 11 gives a start phase of 0, 120, 240 and 90 degrees.
// - Waveform select 000, 001, 010, 100 picks triangle, sawtooth, inverse sawtooth, sine; 111 stops it.
// - Slew-type 0 means linear slewing with the step and interval fields read as linear settings.
// - The linear step field selects 1, 2, 3, 4, 6, 8, 16 or 32 lsb per step.
// - Interval code 0000 makes transitions jump with no slewing and is not for waveform use.
// - Nonzero interval codes set the time between steps, from 4 us up to 5127.92 us.
// - Slew-type 1 means logarithmic slewing with each step 3.125 percent larger than the last.
`timescale 1ns/1ps
`include "dcswc_params.svh"
module dcswc_channel #(
    parameter int          CODE_W      = 12,
    parameter logic [15:0][19:0] STEP_CYCLES = {
        20'(`DCSWC_T15_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T14_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T13_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T12_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T11_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T10_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T09_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T08_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T07_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T06_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T05_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T04_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T03_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T02_NS * `DCSWC_CLK_MHZ / 1000),
        20'(`DCSWC_T01_NS * `DCSWC_CLK_MHZ / 1000),
        20'h00000
    }
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // load trigger pin, active low
    input  wire logic        load_trigger_n,
    // channel output code and slew state
    output logic [CODE_W-1:0] dac_code,
    output logic             slew_busy,
    output logic             log_slew,
    // waveform generator settings
    output dcswc_pkg::dcswc_wave_t wave_kind,
    output logic             gen_active,
    output logic [8:0]       phase_deg
);
    // widths the 16-bit datapath can serve
    generate
        if (CODE_W < 8 || CODE_W > 16) begin : g_bad_width
            $error("dcswc_channel: CODE_W must be 8 to 16");
        end
    endgenerate

    localparam logic [15:0] CODE_MASK = 16'((17'h00001 << CODE_W) - 17'h00001);
    localparam logic [15:0] MID_SCALE = 16'(17'h00001 << (CODE_W - 1));

    dcswc_pkg::dcswc_ctrl_t q;
    dcswc_pkg::dcswc_ctrl_t d;

    logic        load_fall;
    logic [15:0] slew_code;
    logic        slew_busy_w;
    logic        acc;
    logic        commit;
    logic        wr;
    logic        mapped;
    logic [15:0] new_val;
    logic        wcmd;
    logic        bcmd;
    logic        load;
    logic        clear;
    logic [19:0] interval;
    logic        jump;
    logic [5:0]  step_lin;
    logic [31:0] rdata;

    // linear step size lookup
    function automatic logic [5:0] step_of(input logic [2:0] sel);
        logic [5:0] s;
        s = `DCSWC_STEP0;
        unique case (sel)
            3'h0: s = `DCSWC_STEP0;
            3'h1: s = `DCSWC_STEP1;
            3'h2: s = `DCSWC_STEP2;
            3'h3: s = `DCSWC_STEP3;
            3'h4: s = `DCSWC_STEP4;
            3'h5: s = `DCSWC_STEP5;
            3'h6: s = `DCSWC_STEP6;
            3'h7: s = `DCSWC_STEP7;
        endcase
        return s;
    endfunction

    // waveform code decode, other codes flagged
    function automatic dcswc_pkg::dcswc_wave_t wave_of(input logic [2:0] sel);
        dcswc_pkg::dcswc_wave_t w;
        w = dcswc_pkg::DCSWC_WAVE_BAD;
        unique case (sel)
            `DCSWC_W_TRI:  w = dcswc_pkg::DCSWC_WAVE_TRI;
            `DCSWC_W_SAW:  w = dcswc_pkg::DCSWC_WAVE_SAW;
            `DCSWC_W_ISAW: w = dcswc_pkg::DCSWC_WAVE_ISAW;
            `DCSWC_W_SINE: w = dcswc_pkg::DCSWC_WAVE_SINE;
            `DCSWC_W_OFF:  w = dcswc_pkg::DCSWC_WAVE_OFF;
            default:       w = dcswc_pkg::DCSWC_WAVE_BAD;
        endcase
        return w;
    endfunction

    // phase start lookup
    function automatic logic [8:0] phase_of(input logic [1:0] sel);
        logic [8:0] p;
        p = `DCSWC_PH0;
        unique case (sel)
            2'h0: p = `DCSWC_PH0;
            2'h1: p = `DCSWC_PH1;
            2'h2: p = `DCSWC_PH2;
            2'h3: p = `DCSWC_PH3;
        endcase
        return p;
    endfunction

    // falling edge of the load pin
    dcswc_pin_sync u_load_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pin_n   (load_trigger_n),
        .fall    (load_fall)
    );

    // slew settings from the live config
    assign interval = STEP_CYCLES[q.func[`DCSWC_RATE_LSB +: 4]];
    assign jump     = (q.func[`DCSWC_RATE_LSB +: 4] == 4'h0);
    assign step_lin = step_of(q.func[`DCSWC_STEP_LSB +: 3]);

    // output code engine
    dcswc_slew u_slew (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .target     (q.target),
        .interval   (interval),
        .jump       (jump),
        .log_mode   (q.log_slew),
        .step_lin   (step_lin),
        .force_v    (q.force_v),
        .force_code (q.force_code),
        .code       (slew_code),
        .busy       (slew_busy_w)
    );

    // apb phases: pready one cycle after access starts
    assign acc    = psel & penable;
    assign commit = acc & q.pready;
    assign wr     = commit & pwrite;

    // address decode
    always_comb begin
        mapped = 1'b1;
        rdata  = 32'h00000000;
        unique case (paddr)
            `DCSWC_OFS_FUNC:   rdata = {16'h0000, q.func};
            `DCSWC_OFS_CODE:   rdata = {16'h0000, q.hold};
            `DCSWC_OFS_BRD:    rdata = 32'h00000000;
            `DCSWC_OFS_TRIG:   rdata = 32'h00000000;
            `DCSWC_OFS_STATUS: begin
                rdata = {16'h0000, slew_code};
                rdata[`DCSWC_ST_BUSY] = slew_busy_w;
                rdata[`DCSWC_ST_PEND] = q.pending;
                rdata[`DCSWC_ST_BADW] = (q.wave == dcswc_pkg::DCSWC_WAVE_BAD);
            end
            default: begin
                mapped = 1'b0;
                rdata  = 32'h00000000;
            end
        endcase
    end

    // write commands and triggers
    assign new_val = pwdata[15:0] & CODE_MASK;
    assign wcmd    = wr & (paddr == `DCSWC_OFS_CODE);
    assign bcmd    = wr & (paddr == `DCSWC_OFS_BRD) & q.func[`DCSWC_BRD_BIT];
    assign load    = load_fall | (wr & (paddr == `DCSWC_OFS_TRIG) & pwdata[`DCSWC_TRIG_LOAD]);
    assign clear   = wr & (paddr == `DCSWC_OFS_TRIG) & pwdata[`DCSWC_TRIG_CLR];

    // next state of the channel
    always_comb begin
        d         = q;
        d.force_v = 1'b0;

        // bus answer
        d.pready = acc & ~q.pready;
        if (acc & ~q.pready) begin
            d.pslverr = ~mapped;
            d.prdata  = pwrite ? 32'h00000000 : rdata;
        end else begin
            d.pslverr = 1'b0;
        end

        // configuration write
        if (wr & (paddr == `DCSWC_OFS_FUNC)) begin
            d.func = pwdata[15:0];
        end

        // code write, direct or held
        if (wcmd | bcmd) begin
            d.hold = new_val;
            if (q.func[`DCSWC_SYNC_BIT]) begin
                d.pending = 1'b1;
            end else begin
                d.target = new_val;
            end
        end

        // trigger moves the held code, a same-cycle write included
        if (load & q.func[`DCSWC_SYNC_BIT] & d.pending) begin
            d.target  = d.hold;
            d.pending = 1'b0;
        end

        // clear event overrides everything else
        if (clear) begin
            d.force_code = q.func[`DCSWC_CLR_BIT] ? MID_SCALE : 16'h0000;
            d.target     = d.force_code;
            d.force_v    = 1'b1;
            d.pending    = 1'b0;
        end

        // generator settings from the new config
        d.wave       = wave_of(d.func[`DCSWC_WAVE_LSB +: 3]);
        d.gen_active = (d.wave != dcswc_pkg::DCSWC_WAVE_OFF) &&
                       (d.wave != dcswc_pkg::DCSWC_WAVE_BAD);
        d.phase_deg  = phase_of(d.func[`DCSWC_PHASE_LSB +: 2]);
        d.log_slew   = d.func[`DCSWC_LOG_BIT];
    end

    // state register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '{
                pready:     1'b0,
                pslverr:    1'b0,
                prdata:     32'h00000000,
                func:       `DCSWC_FUNC_RST,
                hold:       `DCSWC_CODE_RST,
                target:     `DCSWC_CODE_RST,
                pending:    1'b0,
                force_v:    1'b0,
                force_code: 16'h0000,
                wave:       dcswc_pkg::DCSWC_WAVE_TRI,
                gen_active: 1'b1,
                phase_deg:  `DCSWC_PH0,
                log_slew:   1'b0
            };
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign prdata     = q.prdata;
    assign pready     = q.pready;
    assign pslverr    = q.pslverr;
    assign dac_code   = slew_code[CODE_W-1:0];
    assign slew_busy  = slew_busy_w;
    assign log_slew   = q.log_slew;
    assign wave_kind  = q.wave;
    assign gen_active = q.gen_active;
    assign phase_deg  = q.phase_deg;
endmodule // dcswc_channel

// file: src/dcswc_params.svh
`ifndef DCSWC_PARAMS_SVH
`define DCSWC_PARAMS_SVH

// register byte offsets
`define DCSWC_OFS_FUNC    8'h00
`define DCSWC_OFS_CODE    8'h04
`define DCSWC_OFS_BRD     8'h08
`define DCSWC_OFS_TRIG    8'h0C
`define DCSWC_OFS_STATUS  8'h10

// reset values
`define DCSWC_FUNC_RST    16'h0000
`define DCSWC_CODE_RST    16'h0000

// channel_function_config field positions
`define DCSWC_CLR_BIT     15
`define DCSWC_SYNC_BIT    14
`define DCSWC_BRD_BIT     13
`define DCSWC_PHASE_LSB   11
`define DCSWC_WAVE_LSB    8
`define DCSWC_LOG_BIT     7
`define DCSWC_STEP_LSB    4
`define DCSWC_RATE_LSB    0

// trigger and status bit positions
`define DCSWC_TRIG_LOAD   0
`define DCSWC_TRIG_CLR    1
`define DCSWC_ST_BUSY     16
`define DCSWC_ST_PEND     17
`define DCSWC_ST_BADW     18

// waveform select codes
`define DCSWC_W_TRI       3'h0
`define DCSWC_W_SAW       3'h1
`define DCSWC_W_ISAW      3'h2
`define DCSWC_W_SINE      3'h4
`define DCSWC_W_OFF       3'h7

// phase offsets in degrees
`define DCSWC_PH0         9'd0
`define DCSWC_PH1         9'd120
`define DCSWC_PH2         9'd240
`define DCSWC_PH3         9'd90

// linear code steps in lsb
`define DCSWC_STEP0       6'd1
`define DCSWC_STEP1       6'd2
`define DCSWC_STEP2       6'd3
`define DCSWC_STEP3       6'd4
`define DCSWC_STEP4       6'd6
`define DCSWC_STEP5       6'd8
`define DCSWC_STEP6       6'd16
`define DCSWC_STEP7       6'd32

// log slew growth: step grows by 1/32 per step
`define DCSWC_LOG_SHIFT   5

// clock rate and step intervals in ns
`define DCSWC_CLK_MHZ     100
`define DCSWC_T01_NS      4000
`define DCSWC_T02_NS      8000
`define DCSWC_T03_NS      12000
`define DCSWC_T04_NS      18000
`define DCSWC_T05_NS      27040
`define DCSWC_T06_NS      40480
`define DCSWC_T07_NS      60720
`define DCSWC_T08_NS      91120
`define DCSWC_T09_NS      136720
`define DCSWC_T10_NS      239200
`define DCSWC_T11_NS      418640
`define DCSWC_T12_NS      732560
`define DCSWC_T13_NS      1282000
`define DCSWC_T14_NS      2563960
`define DCSWC_T15_NS      5127920

`endif

// file: src/dcswc_pkg.sv
package dcswc_pkg;

    // decoded waveform kind, one-hot
    typedef enum logic [5:0] {
        DCSWC_WAVE_TRI  = 6'h01,
        DCSWC_WAVE_SAW  = 6'h02,
        DCSWC_WAVE_ISAW = 6'h04,
        DCSWC_WAVE_SINE = 6'h08,
        DCSWC_WAVE_OFF  = 6'h10,
        DCSWC_WAVE_BAD  = 6'h20
    } dcswc_wave_t;

    // pin synchroniser state
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic stable;
        logic fall;
    } dcswc_sync_t;

    // slew engine state
    typedef struct packed {
        logic [15:0] code;
        logic [19:0] cnt;
        logic [20:0] step_fp;
        logic        busy;
    } dcswc_slew_t;

    // channel control state
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [15:0] func;
        logic [15:0] hold;
        logic [15:0] target;
        logic        pending;
        logic        force_v;
        logic [15:0] force_code;
        dcswc_wave_t wave;
        logic        gen_active;
        logic [8:0]  phase_deg;
        logic        log_slew;
    } dcswc_ctrl_t;

endpackage

// file: src/dcswc_pin_sync.sv
`timescale 1ns/1ps
module dcswc_pin_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // active-low pin and its falling edge
    input  wire logic pin_n,
    output logic      fall
);
    dcswc_pkg::dcswc_sync_t q;
    dcswc_pkg::dcswc_sync_t d;

    // three flops, level accepted once s2 and s3 agree
    always_comb begin
        d        = q;
        d.s1     = pin_n;
        d.s2     = q.s1;
        d.s3     = q.s2;
        if (q.s2 == q.s3) begin
            d.stable = q.s3;
        end
        d.fall   = q.stable & ~d.stable;
    end

    // idle high after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, stable: 1'b1, fall: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign fall = q.fall;
endmodule // dcswc_pin_sync

// file: src/dcswc_slew.sv
`timescale 1ns/1ps
`include "dcswc_params.svh"
module dcswc_slew (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // settings
    input  wire logic [15:0] target,
    input  wire logic [19:0] interval,
    input  wire logic        jump,
    input  wire logic        log_mode,
    input  wire logic [5:0]  step_lin,
    // forced load
    input  wire logic        force_v,
    input  wire logic [15:0] force_code,
    // output code
    output logic [15:0]      code,
    output logic             busy
);
    localparam logic [20:0] FP_ONE = 21'h000020;

    dcswc_pkg::dcswc_slew_t q;
    dcswc_pkg::dcswc_slew_t d;
    logic [15:0] amt;
    logic [15:0] diff;
    logic [21:0] grow;

    // step toward target once per interval, never past it
    always_comb begin
        d    = q;
        amt  = log_mode ? q.step_fp[20:5] : {10'h000, step_lin};
        diff = (target > q.code) ? target - q.code : q.code - target;
        grow = {1'b0, q.step_fp} + {6'h00, q.step_fp[20:`DCSWC_LOG_SHIFT]};
        if (force_v) begin
            d.code    = force_code;
            d.cnt     = interval - 20'h00001;
            d.step_fp = FP_ONE;
        end else if (jump) begin
            d.code    = target;
            d.step_fp = FP_ONE;
        end else if (q.code != target) begin
            if (q.cnt == 20'h00000) begin
                d.cnt = interval - 20'h00001;
                if (diff <= amt) begin
                    d.code = target;
                end else if (target > q.code) begin
                    d.code = q.code + amt;
                end else begin
                    d.code = q.code - amt;
                end
                if (log_mode) begin
                    d.step_fp = grow[21] ? 21'h1FFFFF : grow[20:0];
                end
            end else begin
                d.cnt = q.cnt - 20'h00001;
            end
        end else begin
            d.cnt     = interval - 20'h00001;
            d.step_fp = FP_ONE;
        end
        d.busy = (d.code != target);
    end

    // zero-scale after reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            q <= '{code: `DCSWC_CODE_RST, cnt: 20'h00000, step_fp: FP_ONE, busy: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign code = q.code;
    assign busy = q.busy;
endmodule // dcswc_slew

// file: bench/dcswc_channel_checker.sv
`timescale 1ns/1ps
`include "dcswc_params.svh"
module dcswc_channel_checker #(
    parameter int CODE_W = 12
) (
    // clock and reset
    input wire logic                   clk,
    input wire logic                   sys_rst,
    // apb
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [7:0]             paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // pin and channel outputs
    input wire logic                   load_trigger_n,
    input wire logic [CODE_W-1:0]      dac_code,
    input wire logic                   slew_busy,
    input wire logic                   log_slew,
    input wire dcswc_pkg::dcswc_wave_t wave_kind,
    input wire logic                   gen_active,
    input wire logic [8:0]             phase_deg
);
    logic        commit;
    logic [15:0] cfg_q;
    // completed writes per register
    assign commit = psel && penable && pready && pwrite;

    // shadow of the last written configuration
    always_ff @(posedge clk) begin
        if (sys_rst) cfg_q <= 16'h0000;
        else if (commit && paddr == `DCSWC_OFS_FUNC) cfg_q <= pwdata[15:0];
    end

    function automatic logic [8:0] ph_of(input logic [1:0] s);
        case (s)
            2'h0: return 9'd0;
            2'h1: return 9'd120;
            2'h2: return 9'd240;
            default: return 9'd90;
        endcase
    endfunction

    function automatic logic [5:0] wv_of(input logic [2:0] c);
        case (c)
            3'h0: return 6'h01;
            3'h1: return 6'h02;
            3'h2: return 6'h04;
            3'h4: return 6'h08;
            3'h7: return 6'h10;
            default: return 6'h20;
        endcase
    endfunction

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_ready_pulse: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready not a single cycle after access");
    a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h00000000)
        else $error("error answer carries data");
    a_clear_level: assert property (commit && paddr == `DCSWC_OFS_TRIG && pwdata[1] |->
        ##2 dac_code == (cfg_q[15] ? {1'b1, {(CODE_W-1){1'b0}}} : '0))
        else $error("clear level wrong");
    a_code_jump: assert property (commit && paddr == `DCSWC_OFS_CODE && !cfg_q[14] && cfg_q[3:0] == 4'h0
        |-> ##2 dac_code == $past(pwdata[CODE_W-1:0], 2))
        else $error("immediate code not applied");
    a_sync_hold: assert property (commit && paddr == `DCSWC_OFS_CODE && cfg_q[14] && !slew_busy
        |=> $stable(dac_code) [*2])
        else $error("synced code moved early");
    a_brd_ignore: assert property (commit && paddr == `DCSWC_OFS_BRD && !cfg_q[13] && !slew_busy
        |=> $stable(dac_code) [*2])
        else $error("broadcast not ignored");
    a_phase_map: assert property (commit && paddr == `DCSWC_OFS_FUNC
        |-> ##2 phase_deg == ph_of($past(pwdata[12:11], 2)))
        else $error("phase offset wrong");
    a_wave_map: assert property (commit && paddr == `DCSWC_OFS_FUNC
        |-> ##2 wave_kind == wv_of($past(pwdata[10:8], 2)))
        else $error("waveform kind wrong");
    a_gen_valid: assert property (gen_active == (|wave_kind[3:0]))
        else $error("generator enable wrong");
    a_log_copy: assert property (commit && paddr == `DCSWC_OFS_FUNC
        |-> ##2 log_slew == $past(pwdata[7], 2))
        else $error("slew type wrong");
endmodule // dcswc_channel_checker

bind dcswc_channel dcswc_channel_checker #(.CODE_W(CODE_W)) dcswc_channel_checker_inst (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .load_trigger_n(load_trigger_n),
    .dac_code(dac_code), .slew_busy(slew_busy), .log_slew(log_slew), .wave_kind(wave_kind),
    .gen_active(gen_active), .phase_deg(phase_deg));

// file: bench/dcswc_load_pin.sv
`timescale 1ns/1ps
module dcswc_load_pin (
    // clock
    input  wire logic clk,
    // request and pin
    input  wire logic pull,
    output logic      load_trigger_n
);
    int unsigned left_q = 0;
    // holds the pin low eight cycles per request, idles high
    always @(posedge clk) begin
        if (pull) left_q <= 8;
        else if (left_q != 0) left_q <= left_q - 1;
    end
    assign load_trigger_n = (left_q == 0);
endmodule // dcswc_load_pin

// file: bench/dac_channel_slew_waveform_config_bench.sv
`timescale 1ns/1ps
`include "dcswc_params.svh"
module dac_channel_slew_waveform_config_bench;
    logic                   clk = 1'b0;
    logic                   sys_rst = 1'b1;
    logic                   psel = 1'b0;
    logic                   penable = 1'b0;
    logic                   pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h00000000;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   load_trigger_n;
    logic                   pull = 1'b0;
    logic [11:0]            dac_code;
    logic                   slew_busy;
    logic                   log_slew;
    dcswc_pkg::dcswc_wave_t wave_kind;
    logic                   gen_active;
    logic [8:0]             phase_deg;
    logic [31:0]            rd;
    logic                   er;
    int                     n_mismatch = 0;
    int                     checked = 0;
    int                     steps [8] = '{1, 2, 3, 4, 6, 8, 16, 32};
    logic [2:0]             wsel [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7, 3'h3};
    logic [5:0]             wexp [6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
    int                     phx [4] = '{0, 120, 240, 90};

    // short intervals: code 1 is 5 cycles, codes 2 and up 9 cycles
    dcswc_channel #(.CODE_W(12), .STEP_CYCLES({{14{20'd9}}, 20'd5, 20'h00000})) dcswc_channel_inst (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .load_trigger_n(load_trigger_n),
        .dac_code(dac_code), .slew_busy(slew_busy), .log_slew(log_slew), .wave_kind(wave_kind),
        .gen_active(gen_active), .phase_deg(phase_deg));
    dcswc_load_pin dcswc_load_pin_inst (.clk(clk), .pull(pull), .load_trigger_n(load_trigger_n));

    always #5 clk = ~clk;

    task automatic conclude();
        if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one apb transfer, released only after the edge that samples pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        cmp(nm, exp, rd);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // follows a linear slew, checking each step size and the step spacing
    task automatic slew(input int stp, input int n, input logic [11:0] tgt);
        logic [11:0] prev;
        int          k;
        int          cnt;
        int          t0;
        int          t1;
        prev = dac_code;
        cnt = 0;
        t0 = 0;
        t1 = 0;
        for (k = 0; k < 400 && dac_code !== tgt; k++) begin
            @(posedge clk);
            #1;
            if (dac_code !== prev) begin
                cmp("slew step", 32'((tgt - prev > 12'(stp)) ? 12'(stp) : tgt - prev), 32'(dac_code - prev));
                cmp("busy", 32'(dac_code !== tgt), 32'(slew_busy));
                if (cnt == 0) t0 = k;
                t1 = k;
                cnt++;
                prev = dac_code;
            end
        end
        cmp("slew count", 32'h00000004, 32'(cnt));
        cmp("slew span", 32'(3 * n), 32'(t1 - t0));
    endtask

    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rdc("config reset", `DCSWC_OFS_FUNC, 32'h00000000);
        rdc("status reset", `DCSWC_OFS_STATUS, 32'h00000000);
        cmp("wave reset", 32'h00000001, 32'(wave_kind));
        apb(1'b0, 8'h20, 32'h00000000);
        cmp("unmapped err", 32'h00000001, 32'(er));
        cmp("unmapped data", 32'h00000000, rd);
        // immediate update and jump
        wr(`DCSWC_OFS_CODE, 32'h00000123);
        tick(4);
        rdc("status", `DCSWC_OFS_STATUS, 32'h00000123);
        rdc("code", `DCSWC_OFS_CODE, 32'h00000123);
        // clear levels
        wr(`DCSWC_OFS_TRIG, 32'h00000002);
        tick(3);
        rdc("status", `DCSWC_OFS_STATUS, 32'h00000000);
        wr(`DCSWC_OFS_FUNC, 32'h00008000);
        rdc("config", `DCSWC_OFS_FUNC, 32'h00008000);
        wr(`DCSWC_OFS_TRIG, 32'h00000002);
        tick(3);
        rdc("status", `DCSWC_OFS_STATUS, 32'h00000800);
        // synced update by load bit and by pin
        wr(`DCSWC_OFS_FUNC, 32'h00004000);
        wr(`DCSWC_OFS_CODE, 32'h00000055);
        tick(4);
        rdc("status", `DCSWC_OFS_STATUS, 32'h00020800);
        wr(`DCSWC_OFS_TRIG, 32'h00000001);
        tick(4);
        rdc("status", `DCSWC_OFS_STATUS, 32'h00000055);
        wr(`DCSWC_OFS_CODE, 32'h000000AA);
        rdc("status", `DCSWC_OFS_STATUS, 32'h00020055);
        @(posedge clk);
        pull <= 1'b1;
        @(posedge clk);
        pull <= 1'b0;
        tick(20);
        rdc("status", `DCSWC_OFS_STATUS, 32'h000000AA);
        // broadcast ignored, then taken
        wr(`DCSWC_OFS_FUNC, 32'h00000000);
        wr(`DCSWC_OFS_BRD, 32'h00000321);
        tick(4);
        rdc("status", `DCSWC_OFS_STATUS, 32'h000000AA);
        wr(`DCSWC_OFS_FUNC, 32'h00002000);
        wr(`DCSWC_OFS_BRD, 32'h00000321);
        tick(4);
        rdc("status", `DCSWC_OFS_STATUS, 32'h00000321);
        // every waveform code and phase, one invalid code
        for (int i = 0; i < 6; i++) begin
            wr(`DCSWC_OFS_FUNC, 32'({2'(i % 4), wsel[i]}) << `DCSWC_WAVE_LSB);
            tick(3);
            cmp("wave kind", 32'(wexp[i]), 32'(wave_kind));
            cmp("gen active", 32'(i < 4), 32'(gen_active));
            cmp("phase", 32'(phx[i % 4]), 32'(phase_deg));
        end
        wr(`DCSWC_OFS_FUNC, 32'h00000080);
        tick(3);
        cmp("log slew", 32'h00000001, 32'(log_slew));
        // every linear step size, two intervals
        for (int i = 0; i < 8; i++) begin
            wr(`DCSWC_OFS_FUNC, 32'((i << `DCSWC_STEP_LSB) | (i % 2 + 1)));
            wr(`DCSWC_OFS_TRIG, 32'h00000002);
            cmp("linear", 32'h00000000, 32'(log_slew));
            tick(4);
            wr(`DCSWC_OFS_CODE, 32'(3 * steps[i] + 1));
            slew(steps[i], (i % 2) ? 9 : 5, 12'(3 * steps[i] + 1));
        end
        conclude();
    end

    // watchdog
    initial begin
        #500000;
        n_mismatch++;
        conclude();
    end
endmodule // dac_channel_slew_waveform_config_bench
